// ---- inc/sac_pkg.sv ----
`default_nettype none
package sac_pkg;
  // Register select codes held in the low bits of the pointer
  localparam int PTR_SEL_W = 3;
  localparam logic [2:0] SEL_RESULT = 3'h0;
  localparam logic [2:0] SEL_STATUS = 3'h1;
  localparam logic [2:0] SEL_CONFIG = 3'h2;
  localparam logic [2:0] SEL_LOW_LIM = 3'h3;
  localparam logic [2:0] SEL_HIGH_LIM = 3'h4;
  localparam logic [2:0] SEL_HYST = 3'h5;
  localparam logic [2:0] SEL_LOWEST = 3'h6;
  localparam logic [2:0] SEL_HIGHEST = 3'h7;

  // Reset values
  localparam logic [7:0] RST_PTR = 8'h00;
  localparam logic [7:0] RST_CODE = 8'h00;
  localparam logic [1:0] RST_STATUS = 2'h0;
  localparam logic [7:0] RST_CFG = 8'h00;
  localparam logic [7:0] RST_LOW_LIM = 8'h00;
  localparam logic [7:0] RST_HIGH_LIM = 8'hff;
  localparam logic [7:0] RST_HYST = 8'h00;
  localparam logic [7:0] RST_LOWEST = 8'hff;
  localparam logic [7:0] RST_HIGHEST = 8'h00;

  // Field layout of the 16-bit words and of the 8-bit registers
  localparam int WORD_LSB = 4;
  localparam int ALERT_FLAG_BIT = 15;
  localparam int CFG_CYC_HI = 7;
  localparam int CFG_CYC_LO = 5;
  localparam int CFG_HOLD = 4;
  localparam int CFG_FLAG_EN = 3;
  localparam int STS_OVER = 1;
  localparam int STS_UNDER = 0;

  // Conversion timing; the cycle counts are in conversion-clock cycles
  localparam int TRACK_NS = 400;
  localparam int TRACK_MAX_NS = 530;
  localparam logic [3:0] TRACK_CYCLES = 4'h8;
  localparam logic [3:0] SETTLE_CYCLES = 4'h3;
  localparam int CODE_STEPS = 256;
  localparam int CLK_MHZ = 100;

  // Automatic mode interval: unit << (cycle code + shift)
  localparam int INTERVAL_SHIFT = 4;
  localparam int IVL_W = 24;

  typedef enum logic [2:0] {
    I_IDLE, I_ADDR, I_AACK, I_WR, I_WACK, I_RD, I_RACK
  } sac_bus_st_t;

  typedef enum logic [1:0] {
    C_IDLE, C_TRACK, C_STEP
  } sac_conv_st_t;
endpackage : sac_pkg
`default_nettype wire

// ---- src/sac_top.sv ----
// How it works
// [RL1] Cycle starts at acknowledge fall, tracks first
// [RL2] Convert only on result read or auto
// [RL3] Normal mode: result read launches next conversion
// [RL4] Auto mode: interval chosen by config D7..D5
// [RL5] Keep lowest and highest results seen
// [RL6] Hold phase steps DAC by approximation
// [RL7] Balanced DAC code becomes the result
// [RL8] Track eight internal clocks before converting
// [RL9] Straight binary code, step supply/256
// [RL10] Reset loads defined value into every register
// [RL11] First conversion updates result and status
// [RL12] Register changes only on write or event
// [RL13] Power-down disturbs the register contents
// [RL14] Eight data registers plus one pointer
// [RL15] All registers writable except read-only result
// [RL16] First write byte goes into pointer
// [RL17] Pointer selects register for following bytes
// [RL18] Only pointer low three bits are significant
// [RL19] Controller writes zeros to upper pointer bits
// [RL20] Pointer resets to zero, selecting result
// [RL21] Select decode: result, status, config, limits...
// [RL22] Result code sits in bits 11 to 4
// [RL23] Pointer kept between bus transactions
`default_nettype none
module sac_top
  import sac_pkg::*;
#(
  parameter logic [6:0] TARGET_ADDR = 7'h2a,
  parameter int CONV_UNIT_CYC = 100
) (
  input wire logic CLK,
  input wire logic SRST,
  input wire logic CONV_CLK,
  input wire logic SCL,
  input wire logic SDA_I,
  output logic SDA_O,
  output logic SDA_OE,
  input wire logic COMP_HIGH,
  input wire logic POWER_DOWN,
  output logic SAMPLE_SWITCH,
  output logic BALANCE_SWITCH,
  output logic [7:0] DAC_CODE
);

  // Bus and register side, on CLK
  typedef struct packed {
    logic scl1, scl2, scl3;
    logic sda1, sda2, sda3;
    logic pd1, pd2;
    logic dn1, dn2, dn3;
    sac_bus_st_t st;
    logic [3:0] nb;
    logic [7:0] sh;
    logic rw;
    logic mack;
    logic rb;
    logic [1:0] bn;
    logic [7:0] hi_byte;
    logic sda_oe;
    logic sda_lvl;
    logic [7:0] ptr;
    logic [7:0] result;
    logic [1:0] status;
    logic [7:0] cfg;
    logic [7:0] lo_lim;
    logic [7:0] hi_lim;
    logic [7:0] hyst;
    logic [7:0] lowest;
    logic [7:0] highest;
    logic start_tgl;
    logic [IVL_W-1:0] ivl_cnt;
  } sac_bus_state_t;

  // Converter side, on CONV_CLK
  typedef struct packed {
    logic r1, r2;
    logic s1, s2, s3;
    logic m1, m2;
    sac_conv_st_t st;
    logic pend;
    logic [3:0] cnt;
    logic [2:0] bi;
    logic [7:0] code;
    logic [7:0] res;
    logic done_tgl;
    logic samp;
    logic bal;
  } sac_conv_state_t;

  sac_bus_state_t q, d;
  sac_conv_state_t cq, cd;

  logic scl_rise, scl_fall, start_c, stop_c, done_ev, auto_on;
  logic is16;
  logic [15:0] rd_word;
  logic [7:0] rd_byte;
  logic [7:0] wr_val;
  logic [8:0] over_clr, under_clr;
  logic [IVL_W-1:0] ivl;
  logic [7:0] sar_code;

  // Places an 8-bit code in its 16-bit word
  function automatic logic [15:0] code_word(input logic [7:0] c);
    code_word = 16'(c) << WORD_LSB; // see [RL22]
  endfunction : code_word

  // Read word for the selected register
  always_comb begin
    rd_word = 16'h0000;
    is16 = 1'b1;
    case (q.ptr[PTR_SEL_W-1:0]) // see [RL17] see [RL21]
      SEL_RESULT: begin
        rd_word = code_word(q.result);
        rd_word[ALERT_FLAG_BIT] = q.cfg[CFG_FLAG_EN] & (|q.status);
      end
      SEL_STATUS: begin
        rd_word = {8'h00, 6'h00, q.status};
        is16 = 1'b0;
      end
      SEL_CONFIG: begin
        rd_word = {8'h00, q.cfg};
        is16 = 1'b0;
      end
      SEL_LOW_LIM: rd_word = code_word(q.lo_lim);
      SEL_HIGH_LIM: rd_word = code_word(q.hi_lim);
      SEL_HYST: rd_word = code_word(q.hyst);
      SEL_LOWEST: rd_word = code_word(q.lowest); // see [RL5]
      SEL_HIGHEST: rd_word = code_word(q.highest);
      default: rd_word = 16'h0000;
    endcase
    rd_byte = (is16 && !q.rb) ? rd_word[15:8] : rd_word[7:0];
  end

  // Bus engine, register file and conversion launch
  always_comb begin
    d = q;
    d.scl1 = SCL;
    d.scl2 = q.scl1;
    d.scl3 = q.scl2;
    d.sda1 = SDA_I;
    d.sda2 = q.sda1;
    d.sda3 = q.sda2;
    d.pd1 = POWER_DOWN;
    d.pd2 = q.pd1;
    d.dn1 = cq.done_tgl;
    d.dn2 = q.dn1;
    d.dn3 = q.dn2;
    scl_rise = q.scl2 & ~q.scl3;
    scl_fall = ~q.scl2 & q.scl3;
    start_c = q.scl2 & q.scl3 & q.sda3 & ~q.sda2;
    stop_c = q.scl2 & q.scl3 & ~q.sda3 & q.sda2;
    done_ev = q.dn2 ^ q.dn3;
    auto_on = |q.cfg[CFG_CYC_HI:CFG_CYC_LO];
    wr_val = (q.bn == 2'd2) ? {q.hi_byte[3:0], q.sh[7:4]} : q.sh;
    if (scl_rise && q.st != I_RD && q.st != I_RACK) begin
      d.sh = {q.sh[6:0], q.sda2};
      d.nb = q.nb + 4'd1;
    end
    case (q.st)
      I_IDLE: d.sda_oe = 1'b0;
      I_ADDR: if (scl_fall && q.nb == 4'd8) begin
        d.nb = 4'd0;
        if (q.sh[7:1] == TARGET_ADDR) begin
          // ACK drive pulls SDA low: the conversion cycle starts here
          d.sda_oe = 1'b1;
          d.rw = q.sh[0];
          d.st = I_AACK;
          d.rb = 1'b0;
          if (q.sh[0] && !auto_on && q.ptr[PTR_SEL_W-1:0] == SEL_RESULT)
            d.start_tgl = ~q.start_tgl; // see [RL1] see [RL2] see [RL3]
        end else begin
          d.st = I_IDLE;
        end
      end
      I_AACK: if (scl_fall) begin
        if (q.rw) begin
          d.sh = rd_byte;
          d.sda_oe = ~rd_byte[7];
          d.nb = 4'd1;
          d.st = I_RD;
        end else begin
          d.sda_oe = 1'b0;
          d.nb = 4'd0;
          d.bn = 2'd0;
          d.st = I_WR;
        end
      end
      I_WR: if (scl_fall && q.nb == 4'd8) begin
        d.nb = 4'd0;
        d.sda_oe = 1'b1;
        d.st = I_WACK;
        if (q.bn == 2'd0) begin
          // Upper pointer bits are held at zero; senders keep them zero
          d.ptr = {5'h00, q.sh[PTR_SEL_W-1:0]}; // see [RL16] see [RL18]
          d.bn = 2'd1; // see [RL19]
        end else if (q.bn == 2'd1 && is16) begin
          d.hi_byte = q.sh;
          d.bn = 2'd2;
        end else begin
          d.bn = 2'd1;
          // Storing an equal word leaves the register as it was, except status, where written ones clear set bits
          case (q.ptr[PTR_SEL_W-1:0]) // see [RL12] see [RL14]
            SEL_RESULT: d.result = q.result; // see [RL15]
            SEL_STATUS: d.status = q.status & ~q.sh[1:0];
            SEL_CONFIG: d.cfg = q.sh;
            SEL_LOW_LIM: d.lo_lim = wr_val;
            SEL_HIGH_LIM: d.hi_lim = wr_val;
            SEL_HYST: d.hyst = wr_val;
            SEL_LOWEST: d.lowest = wr_val;
            SEL_HIGHEST: d.highest = wr_val;
            default: d.result = q.result;
          endcase
        end
      end
      I_WACK: if (scl_fall) begin
        d.sda_oe = 1'b0;
        d.nb = 4'd0; // The ack clock also bumped the bit count
        d.st = I_WR;
      end
      I_RD: if (scl_fall) begin
        if (q.nb == 4'd8) begin
          d.sda_oe = 1'b0;
          d.st = I_RACK;
        end else begin
          d.sh = {q.sh[6:0], 1'b0};
          d.sda_oe = ~q.sh[6];
          d.nb = q.nb + 4'd1;
        end
      end
      I_RACK: begin
        if (scl_rise)
          d.mack = ~q.sda2;
        if (scl_fall) begin
          if (q.mack) begin
            d.rb = ~q.rb;
            d.sh = (is16 && q.rb) ? rd_word[15:8] : rd_word[7:0];
            d.sda_oe = is16 && q.rb ? ~rd_word[15] : ~rd_word[7];
            d.nb = 4'd1;
            d.st = I_RD;
          end else begin
            d.st = I_IDLE;
          end
        end
      end
      default: d.st = I_IDLE;
    endcase
    // Start and stop override any bit in flight; pointer survives both
    if (start_c) begin
      d.st = I_ADDR;
      d.nb = 4'd0;
      d.sda_oe = 1'b0; // see [RL23]
    end else if (stop_c) begin
      d.st = I_IDLE;
      d.sda_oe = 1'b0;
    end
    // Interval timer for automatic mode
    ivl = IVL_W'(CONV_UNIT_CYC)
          << (4'(q.cfg[CFG_CYC_HI:CFG_CYC_LO]) + 4'(INTERVAL_SHIFT));
    if (!auto_on) begin
      d.ivl_cnt = '0;
    end else if (q.ivl_cnt == '0) begin
      d.start_tgl = ~q.start_tgl; // see [RL4] see [RL2]
      d.ivl_cnt = ivl - IVL_W'(1);
    end else begin
      d.ivl_cnt = q.ivl_cnt - IVL_W'(1);
    end
    // Result arrival; hardware set of alert bits wins over a write clear
    over_clr = {1'b0, cq.res} + {1'b0, q.hyst};
    under_clr = {1'b0, q.lo_lim} + {1'b0, q.hyst};
    if (done_ev) begin
      d.result = cq.res; // see [RL7] see [RL11]
      if (cq.res < q.lowest)
        d.lowest = cq.res; // see [RL5]
      if (cq.res > q.highest)
        d.highest = cq.res;
      if (!q.cfg[CFG_HOLD] && over_clr < {1'b0, q.hi_lim})
        d.status[STS_OVER] = 1'b0;
      if (!q.cfg[CFG_HOLD] && {1'b0, cq.res} > under_clr)
        d.status[STS_UNDER] = 1'b0;
      if (cq.res > q.hi_lim)
        d.status[STS_OVER] = 1'b1; // see [RL11]
      if (cq.res < q.lo_lim)
        d.status[STS_UNDER] = 1'b1;
    end
    // Power-down and reset both reload the register set
    if (SRST || q.pd2) begin
      d.ptr = RST_PTR; // see [RL20] see [RL13]
      d.result = RST_CODE; // see [RL10]
      d.status = RST_STATUS;
      d.cfg = RST_CFG;
      d.lo_lim = RST_LOW_LIM;
      d.hi_lim = RST_HIGH_LIM;
      d.hyst = RST_HYST;
      d.lowest = RST_LOWEST;
      d.highest = RST_HIGHEST;
      d.ivl_cnt = '0;
    end
    if (SRST) begin
      d.st = I_IDLE;
      d.scl1 = 1'b1;
      d.scl2 = 1'b1;
      d.scl3 = 1'b1;
      d.sda1 = 1'b1;
      d.sda2 = 1'b1;
      d.sda3 = 1'b1;
      d.nb = 4'd0;
      d.bn = 2'd0;
      d.rb = 1'b0;
      d.rw = 1'b0;
      d.mack = 1'b0;
      d.sh = 8'h00;
      d.hi_byte = 8'h00;
      d.sda_oe = 1'b0;
      d.sda_lvl = 1'b0;
      d.start_tgl = 1'b0;
    end
  end

  always_ff @(posedge CLK) begin
    q <= d;
  end

  // Comparator decision on the current trial bit
  always_comb begin
    sar_code = cq.code;
    if (!cq.m2)
      sar_code[cq.bi] = 1'b0; // see [RL6] see [RL9]
  end

  // Converter sequencer: track, then one bit per settle window
  always_comb begin
    cd = cq;
    cd.r1 = SRST;
    cd.r2 = cq.r1;
    cd.s1 = q.start_tgl;
    cd.s2 = cq.s1;
    cd.s3 = cq.s2;
    cd.m1 = COMP_HIGH;
    cd.m2 = cq.m1;
    case (cq.st)
      C_IDLE: if (cq.pend) begin
        cd.pend = 1'b0;
        cd.st = C_TRACK;
        cd.cnt = 4'd0;
        cd.samp = 1'b1; // see [RL1]
        cd.bal = 1'b1;
        cd.code = 8'h00;
      end
      C_TRACK: begin
        cd.cnt = cq.cnt + 4'd1;
        if (cq.cnt == TRACK_CYCLES - 4'd1) begin
          // Switch opens after the eighth cycle of tracking
          cd.samp = 1'b0; // see [RL8]
          cd.bal = 1'b0;
          cd.st = C_STEP;
          cd.cnt = 4'd0;
          cd.bi = 3'd7;
          cd.code = 8'h80;
        end
      end
      C_STEP: begin
        // Wait covers the comparator synchroniser latency
        cd.cnt = cq.cnt + 4'd1;
        if (cq.cnt == SETTLE_CYCLES - 4'd1) begin
          cd.cnt = 4'd0;
          cd.code = sar_code;
          if (cq.bi == 3'd0) begin
            cd.res = sar_code; // see [RL7]
            cd.done_tgl = ~cq.done_tgl;
            cd.st = C_IDLE;
          end else begin
            cd.bi = cq.bi - 3'd1;
            cd.code[cq.bi - 3'd1] = 1'b1; // see [RL6]
          end
        end
      end
      default: cd.st = C_IDLE;
    endcase
    // A launch during a conversion waits; set beats the idle clear
    if (cq.s2 ^ cq.s3)
      cd.pend = 1'b1;
    if (cq.r2) begin
      cd.st = C_IDLE;
      cd.pend = 1'b0;
      cd.cnt = 4'd0;
      cd.bi = 3'd7;
      cd.code = 8'h00;
      cd.res = RST_CODE;
      cd.done_tgl = 1'b0;
      cd.samp = 1'b0;
      cd.bal = 1'b0;
      cd.s3 = cq.s2;
    end
  end

  always_ff @(posedge CONV_CLK) begin
    cq <= cd;
  end

  assign SDA_O = q.sda_lvl;
  assign SDA_OE = q.sda_oe;
  assign SAMPLE_SWITCH = cq.samp;
  assign BALANCE_SWITCH = cq.bal;
  assign DAC_CODE = cq.code;
endmodule : sac_top
`default_nettype wire

// ---- tb/sac_assertions.sv ----
`default_nettype none
module sac_assertions
  import sac_pkg::*;
#(
  parameter int CONV_UNIT_CYC = 100
) (
  input wire logic CLK,
  input wire logic SRST,
  input wire logic CONV_CLK,
  input wire logic SCL,
  input wire logic SDA_I,
  input wire logic SDA_O,
  input wire logic SDA_OE,
  input wire logic COMP_HIGH,
  input wire logic POWER_DOWN,
  input wire logic SAMPLE_SWITCH,
  input wire logic BALANCE_SWITCH,
  input wire logic [7:0] DAC_CODE
);
  timeunit 1ns;
  timeprecision 100ps;
  // Track phase, then a hold phase of at least eight cycles
  sequence s_track;
    SAMPLE_SWITCH [*8] ##1 !SAMPLE_SWITCH;
  endsequence
  sequence s_hold;
    !SAMPLE_SWITCH [*8];
  endsequence
  sequence s_first_trial;
    ##[2:4] (DAC_CODE[6] && DAC_CODE[5:0] == 6'h00);
  endsequence

  // Converter side, on the conversion clock
  a_switch_pair: assert property (
    @(posedge CONV_CLK) disable iff (SRST) SAMPLE_SWITCH == BALANCE_SWITCH)
    else $error("switches disagree");
  a_track_eight: assert property (
    @(posedge CONV_CLK) disable iff (SRST) $rose(SAMPLE_SWITCH) |-> s_track)
    else $error("track phase length wrong");
  a_hold_phase: assert property (
    @(posedge CONV_CLK) disable iff (SRST) $fell(SAMPLE_SWITCH) |-> s_hold)
    else $error("hold phase cut short");
  a_dac_start: assert property (
    @(posedge CONV_CLK) disable iff (SRST)
    $fell(SAMPLE_SWITCH) |-> DAC_CODE == 8'h80)
    else $error("first trial not mid-scale");
  a_approx_step: assert property (
    @(posedge CONV_CLK) disable iff (SRST)
    $fell(SAMPLE_SWITCH) |-> s_first_trial)
    else $error("second trial bit not set");

  // Bus side: open drain, changes only just after a clock fall
  a_drive_low: assert property (
    @(posedge CLK) disable iff (SRST) SDA_OE |-> !SDA_O)
    else $error("data pin driven high");
  a_ack_stands: assert property (
    @(posedge CLK) disable iff (SRST)
    $rose(SDA_OE) |-> SDA_OE until_with $fell(SCL))
    else $error("low level dropped early");
  a_oe_timing: assert property (
    @(posedge CLK) disable iff (SRST)
    $changed(SDA_OE) |-> $past(SCL, 5) && !$past(SCL, 2))
    else $error("data pin moved off slot");
endmodule : sac_assertions

bind sac_top sac_assertions #(.CONV_UNIT_CYC(CONV_UNIT_CYC)) i_chk (
  .CLK(CLK), .SRST(SRST), .CONV_CLK(CONV_CLK), .SCL(SCL), .SDA_I(SDA_I),
  .SDA_O(SDA_O), .SDA_OE(SDA_OE), .COMP_HIGH(COMP_HIGH),
  .POWER_DOWN(POWER_DOWN), .SAMPLE_SWITCH(SAMPLE_SWITCH),
  .BALANCE_SWITCH(BALANCE_SWITCH), .DAC_CODE(DAC_CODE)
);
`default_nettype wire

// ---- tb/sac_bus_host.sv ----
`default_nettype none
module sac_bus_host #(
  parameter logic [6:0] ADDR = 7'h2a,
  parameter int HALF = 10
) (
  input wire logic clk,
  input wire logic sda_line,
  output logic scl,
  output logic sda_drv
);
  timeunit 1ns;
  timeprecision 100ps;
  // Bus idles released and high; the clock stands still between frames
  initial begin
    scl = 1'b1;
    sda_drv = 1'b1;
  end
  task automatic tick(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask : tick
  // Data moves two cycles after the fall, so no false start or stop
  task automatic bit_slot(input logic b, output logic r);
    tick(2);
    sda_drv = b;
    tick(HALF);
    scl = 1'b1;
    tick(HALF);
    r = sda_line;
    scl = 1'b0;
  endtask : bit_slot
  task automatic start();
    tick(HALF);
    sda_drv = 1'b0;
    tick(HALF);
    scl = 1'b0;
  endtask : start
  task automatic stop();
    tick(2);
    sda_drv = 1'b0;
    tick(HALF);
    scl = 1'b1;
    tick(HALF);
    sda_drv = 1'b1;
  endtask : stop
  task automatic put(input logic [7:0] b, output logic nak);
    logic r;
    for (int i = 7; i >= 0; i--) bit_slot(b[i], r);
    bit_slot(1'b1, nak);
  endtask : put
  task automatic get(input logic last, output logic [7:0] b);
    logic r;
    for (int i = 7; i >= 0; i--) bit_slot(1'b1, b[i]);
    bit_slot(last, r);
  endtask : get
  // Pointer byte always leads a write
  task automatic wr(input logic [7:0] ptr, input logic [15:0] d,
                    input int n);
    logic k;
    start();
    put({ADDR, 1'b0}, k);
    put(ptr, k);
    if (n == 2) put(d[15:8], k);
    if (n > 0) put(d[7:0], k);
    stop();
  endtask : wr
  task automatic rd(input int n, output logic [15:0] d);
    logic k;
    d = 16'h0000;
    start();
    put({ADDR, 1'b1}, k);
    if (n == 2) get(1'b0, d[15:8]);
    get(1'b1, d[7:0]);
    stop();
  endtask : rd
endmodule : sac_bus_host
`default_nettype wire

// ---- tb/sac_top_tb.sv ----
`default_nettype none
module sac_top_tb
  import sac_pkg::*;
;
  timeunit 1ns;
  timeprecision 100ps;
  typedef struct packed {
    logic [2:0] sel;
    logic [1:0] nb;
    logic [15:0] rst;
    logic [15:0] wr;
    logic [15:0] exp;
  } sac_row_t;
  // Lowest already saw the launch of the opening read, hence zero
  sac_row_t rows [8] = '{
    '{3'h1, 2'h1, 16'h0000, 16'h0003, 16'h0000},
    '{3'h2, 2'h1, 16'h0000, 16'h0018, 16'h0018},
    '{3'h3, 2'h2, 16'h0000, 16'h0a50, 16'h0a50},
    '{3'h4, 2'h2, 16'h0ff0, 16'h0c30, 16'h0c30},
    '{3'h5, 2'h2, 16'h0000, 16'h0010, 16'h0010},
    '{3'h6, 2'h2, 16'h0000, 16'h0800, 16'h0800},
    '{3'h7, 2'h2, 16'h0000, 16'h0120, 16'h0120},
    '{3'h0, 2'h2, 16'h0000, 16'h0ff0, 16'h8000}
  };
  logic clk = 1'b0;
  logic conv_clk = 1'b0;
  logic srst = 1'b1;
  logic pdn = 1'b0;
  logic [7:0] vin = 8'h00;
  logic scl, sda_drv, sda_o, sda_oe, samp, bal;
  logic [7:0] dac;
  wire logic sda;
  int n_mismatch = 0;
  int check_count = 0;
  int n_conv = 0;
  // Pull-up line; comparator is an ideal input against the trial code
  assign sda = sda_drv && !sda_oe;
  always #5 clk = ~clk;
  initial begin
    #13;
    forever #40 conv_clk = ~conv_clk;
  end
  always @(posedge samp) n_conv++;
  sac_top #(.CONV_UNIT_CYC(2)) i_dut (
    .CLK(clk), .SRST(srst), .CONV_CLK(conv_clk), .SCL(scl), .SDA_I(sda),
    .SDA_O(sda_o), .SDA_OE(sda_oe), .COMP_HIGH(vin >= dac),
    .POWER_DOWN(pdn), .SAMPLE_SWITCH(samp), .BALANCE_SWITCH(bal),
    .DAC_CODE(dac)
  );
  sac_bus_host i_host (
    .clk(clk), .sda_line(sda), .scl(scl), .sda_drv(sda_drv)
  );
  task automatic chk(input string what, input logic [15:0] seen, exp);
    check_count++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("wrong value %s expected %h seen %h", what, exp, seen);
    end
  endtask : chk
  task automatic results();
    if (n_mismatch == 0 && check_count > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask : results
  // Hang guard, well past the expected run length
  initial begin
    #600_000;
    n_mismatch++;
    results();
  end
  initial begin
    sac_row_t r;
    logic [15:0] d;
    int c;
    // Reset held long enough for the conversion domain to see it
    repeat (40) @(posedge clk);
    #1 srst = 1'b0;
    repeat (5) @(posedge clk);
    i_host.rd(2, d);
    chk("first result", d, 16'h0000);
    repeat (600) @(posedge clk);
    chk("launches", 16'(n_conv), 16'h0001);
    foreach (rows[i]) begin
      r = rows[i];
      i_host.wr({5'h00, r.sel}, 16'h0000, 0);
      i_host.rd(int'(r.nb), d);
      chk("reset value", d, r.rst);
      i_host.wr({5'h00, r.sel}, r.wr, int'(r.nb));
      i_host.rd(int'(r.nb), d);
      chk("read back", d, r.exp);
    end
    chk("launches", 16'(n_conv), 16'h0003);
    // Input of 5b hex with the alert flag switched off
    i_host.wr(8'h02, 16'h0000, 1);
    vin = 8'h5b;
    i_host.wr(8'h00, 16'h0000, 0);
    i_host.rd(2, d);
    repeat (600) @(posedge clk);
    i_host.rd(2, d);
    chk("converted code", d, 16'h05b0);
    i_host.wr(8'h07, 16'h0000, 0);
    i_host.rd(2, d);
    chk("highest", d, 16'h05b0);
    // Code below the low limit sets the under-range flag, with hold off
    i_host.wr(8'h01, 16'h0000, 0);
    i_host.rd(1, d);
    chk("under alert", d, 16'h0001);
    // Stray upper pointer bits, then a read with no pointer write
    i_host.wr(8'hfb, 16'h0000, 0);
    i_host.rd(2, d);
    chk("masked pointer", d, 16'h0a50);
    i_host.rd(2, d);
    chk("kept pointer", d, 16'h0a50);
    // Automatic mode launches with the bus quiet, and stops again
    c = n_conv;
    i_host.wr(8'h02, 16'h0020, 1);
    repeat (3000) @(posedge clk);
    chk("auto launches", 16'(n_conv - c > 5), 16'h0001);
    i_host.wr(8'h02, 16'h0000, 1);
    repeat (800) @(posedge clk);
    c = n_conv;
    repeat (3000) @(posedge clk);
    chk("auto stopped", 16'(n_conv - c), 16'h0000);
    // Power-down reloads registers and the pointer
    #1 pdn = 1'b1;
    repeat (4) @(posedge clk);
    #1 pdn = 1'b0;
    repeat (10) @(posedge clk);
    i_host.rd(2, d);
    chk("result after pd", d, 16'h0000);
    i_host.wr(8'h04, 16'h0000, 0);
    i_host.rd(2, d);
    chk("limit after pd", d, 16'h0ff0);
    results();
  end
endmodule : sac_top_tb
`default_nettype wire
